// file: core/interrupt_level_priority_control.sv
// Purpose: level priority and in-service tracking for maskable irqs
// Assumes: classic wishbone, requests arrive already enable-gated
// Notes: one clock, async active-low reset
// Notes on behaviour
// - bit 7 of in-service register shows non-maskable handling, resets 0
// - each source has 2-bit level, 00 is level 1, 11 level 4
// - among competing requests the higher configured level wins
// - level register writes take effect only while level control is on
// - external source n level sits at bits 2n+1 and 2n
// - serial low byte: serial0, serial0 fifo, i2c bus0, i2c bus1
// - serial high byte: uart0 rx, tx, queue; bits 15:14 unused
// - external levels cover first enable group, serial levels the second
// - level registers 16-bit, byte or halfword writable, reset zero
// - enable bit 0 turns level handling on, resets to 0
// - on accept set nmi bit or in-service bit of source level
// - refuse maskable requests below highest set in-service level
// - each in-service write clears only highest set bit; code drops the write while level control is off
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ilpc_consts.svh"
module interrupt_level_priority_control #(
   parameter int NUM_EXT = `NUM_EXT,
   parameter int NUM_SER = `NUM_SER
)(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NUM_EXT-1:0] ext_irq,
   input wire logic [NUM_SER-1:0] serial_irq,
   input wire logic nmi_req,
   input wire logic cpu_accept,
   output logic req_valid,
   output logic req_nmi,
   output ilpc_pkg::src_id_t req_src,
   output ilpc_pkg::level_t req_level,
   output logic irq_out
);
   localparam int NSRC = NUM_EXT + NUM_SER;

   logic level_ctrl_on;
   logic [7:0] in_service_level_reg;
   logic [15:0] external_irq_level_select;
   logic [15:0] serial_irq_level_select;
   ilpc_pkg::evt_t evt_status;
   ilpc_pkg::evt_t evt_mask;
   ilpc_pkg::evt_t evt_set;
   logic [NSRC-1:0] all_req;
   ilpc_pkg::level_t src_level [NSRC];
   logic [15:0] word_idx;
   logic bus_req;
   logic wr_now;
   logic lo_wr;
   logic hi_wr;
   logic [3:0] maskable_in_service_bits;
   logic [2:0] floor_level;
   logic floor_on;
   logic best_found;
   ilpc_pkg::level_t best_lvl;
   ilpc_pkg::src_id_t best_idx;
   logic [31:0] next_rdata;
   logic [7:0] next_in_service;
   // one-hot register hits and their write strobes
   logic hit_enable;
   logic hit_in_service;
   logic hit_ext_level;
   logic hit_ser_level;
   logic hit_evt_status;
   logic hit_evt_mask;
   logic wr_enable;
   logic wr_in_service;
   logic wr_ext_level;
   logic wr_ser_level;
   logic wr_evt_status;
   logic wr_evt_mask;

   // two-bit field n of a level register
   function automatic ilpc_pkg::level_t field_of(input logic [15:0] r,
                                                 input int n);
      field_of = r[2*n +: 2];
   endfunction

   // byte-lane merge, keeps lanes not selected
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic lo,
                                           input logic hi);
      merge16 = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
   endfunction

   // register decode, shared by every write strobe
   function automatic logic reg_hit(input logic [15:0] idx,
                                    input logic [15:0] ofs);
      reg_hit = (idx == ofs);
   endfunction

   // clears the highest set bit only, nmi bit counts highest
   function automatic logic [7:0] drop_top(input logic [7:0] r);
      logic found;
      drop_top = r;
      found = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         if (r[i] && !found)
         begin
            drop_top[i] = 1'b0;
            found = 1'b1;
         end
      end
   endfunction

   assign word_idx = wb_adr_i[17:2];
   assign bus_req = wb_cyc_i & wb_stb_i;
   // write lands at the edge where the master sees ack
   assign wr_now = bus_req & wb_we_i & wb_ack_o;
   assign lo_wr = wb_sel_i[0];
   assign hi_wr = wb_sel_i[1];
   assign all_req = {serial_irq, ext_irq};
   assign maskable_in_service_bits = in_service_level_reg[3:0];

   // each strobe lands only at the edge that carries ack
   assign hit_enable = reg_hit(word_idx, `OFS_ENABLE);
   assign hit_in_service = reg_hit(word_idx, `OFS_IN_SERVICE);
   assign hit_ext_level = reg_hit(word_idx, `OFS_EXT_LEVEL);
   assign hit_ser_level = reg_hit(word_idx, `OFS_SER_LEVEL);
   assign hit_evt_status = reg_hit(word_idx, `OFS_EVT_STATUS);
   assign hit_evt_mask = reg_hit(word_idx, `OFS_EVT_MASK);
   assign wr_enable = wr_now & hit_enable;
   assign wr_in_service = wr_now & hit_in_service;
   assign wr_ext_level = wr_now & hit_ext_level;
   assign wr_ser_level = wr_now & hit_ser_level;
   assign wr_evt_status = wr_now & hit_evt_status;
   assign wr_evt_mask = wr_now & hit_evt_mask;

   generate
      for (genvar g = 0; g < NSRC; g++)
      begin : g_lvl
         if (g < NUM_EXT)
         begin : g_ext
            assign src_level[g] = field_of(external_irq_level_select, g);
         end
         else
         begin : g_ser
            assign src_level[g] = field_of(serial_irq_level_select, g - NUM_EXT);
         end
      end
   endgenerate

   // classic wishbone answer, one cycle after request, dropped next cycle
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= bus_req & ~wb_ack_o;
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (word_idx)
         `OFS_ENABLE: next_rdata[`BIT_ON] = level_ctrl_on;
         `OFS_IN_SERVICE: next_rdata[7:0] = in_service_level_reg;
         `OFS_EXT_LEVEL: next_rdata[15:0] = external_irq_level_select;
         `OFS_SER_LEVEL: next_rdata[15:0] = serial_irq_level_select;
         `OFS_EVT_STATUS: next_rdata[2:0] = evt_status;
         `OFS_EVT_MASK: next_rdata[2:0] = evt_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         wb_dat_o <= 32'h0000_0000;
      else if (bus_req & ~wb_ack_o)
         wb_dat_o <= next_rdata;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         level_ctrl_on <= 1'b0;
      else if (wr_enable && lo_wr)
         level_ctrl_on <= wb_dat_i[`BIT_ON];
   end

   // writes while off are dropped, software must quiesce irqs first
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         external_irq_level_select <= `RST_LEVEL;
      else if (wr_ext_level && level_ctrl_on)
         external_irq_level_select <= merge16(external_irq_level_select,
                                              wb_dat_i, lo_wr, hi_wr);
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         serial_irq_level_select <= `RST_LEVEL;
      else if (wr_ser_level && level_ctrl_on)
         serial_irq_level_select <= merge16(serial_irq_level_select,
                                            wb_dat_i, lo_wr, hi_wr)
                                    & `SER_USED_MASK;
   end

   // floor of acceptance from highest maskable in-service bit
   always_comb
   begin
      floor_on = 1'b0;
      floor_level = 3'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (maskable_in_service_bits[i])
         begin
            floor_on = 1'b1;
            floor_level = 3'(i);
         end
      end
      // nmi in service holds every maskable level off
      if (in_service_level_reg[`BIT_NMI])
      begin
         floor_on = 1'b1;
         floor_level = 3'h4;
      end
   end

   // with control off every source counts as level 1, no floor
   always_comb
   begin
      best_found = 1'b0;
      best_lvl = 2'h0;
      best_idx = 4'h0;
      for (int i = 0; i < NSRC; i++)
      begin
         if (all_req[i] &&
             (!level_ctrl_on || !floor_on ||
              {1'b0, src_level[i]} >= floor_level) &&
             (!best_found ||
              (level_ctrl_on && src_level[i] > best_lvl)))
         begin
            best_found = 1'b1;
            best_lvl = level_ctrl_on ? src_level[i] : 2'h0;
            best_idx = 4'(i);
         end
      end
   end

   // nmi always outranks maskable requests
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         req_valid <= 1'b0;
         req_nmi <= 1'b0;
         req_src <= 4'h0;
         req_level <= 2'h0;
      end
      else if (cpu_accept)
      begin
         req_valid <= 1'b0;
         req_nmi <= 1'b0;
      end
      else
      begin
         req_valid <= nmi_req | best_found;
         req_nmi <= nmi_req;
         req_src <= best_idx;
         req_level <= best_lvl;
      end
   end

   // clear of the top bit first, then accept sets so a set wins
   always_comb
   begin
      next_in_service = in_service_level_reg;
      if (wr_in_service && level_ctrl_on)
      begin
         next_in_service = drop_top(in_service_level_reg);
      end
      if (cpu_accept && req_valid && level_ctrl_on)
      begin
         if (req_nmi)
            next_in_service[`BIT_NMI] = 1'b1;
         else
            next_in_service[req_level] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         in_service_level_reg <= `RST_IN_SERVICE;
      else
         in_service_level_reg <= next_in_service;
   end

   // a refused write still answers, only the event bit records it
   always_comb
   begin
      evt_set = 3'h0;
      evt_set[`EVT_MASKABLE] = cpu_accept & req_valid & ~req_nmi;
      evt_set[`EVT_NMI] = cpu_accept & req_valid & req_nmi;
      evt_set[`EVT_LOCKED_WR] = ~level_ctrl_on &
                                (wr_ext_level | wr_ser_level |
                                 wr_in_service);
   end

   // write-one-to-clear, a new event in the same cycle survives
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         evt_status <= 3'h0;
      else if (wr_evt_status && lo_wr)
         evt_status <= (evt_status & ~wb_dat_i[2:0]) | evt_set;
      else
         evt_status <= evt_status | evt_set;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         evt_mask <= 3'h0;
      else if (wr_evt_mask && lo_wr)
         evt_mask <= wb_dat_i[2:0];
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         irq_out <= 1'b0;
      else
         irq_out <= |(evt_status & evt_mask);
   end
endmodule // interrupt_level_priority_control

// file: shared/ilpc_consts.svh
// Purpose: offsets, field positions, reset values for level control
// Assumes: offsets are word indices, byte address is four times index
// Notes: definitions only
`ifndef ILPC_CONSTS_SVH
`define ILPC_CONSTS_SVH
`define OFS_ENABLE 16'hF020
`define OFS_IN_SERVICE 16'hF022
`define OFS_EXT_LEVEL 16'hF024
`define OFS_SER_LEVEL 16'hF026
`define OFS_EVT_STATUS 16'hF030
`define OFS_EVT_MASK 16'hF032
`define RST_LEVEL 16'h0000
`define RST_IN_SERVICE 8'h00
`define BIT_ON 0
`define BIT_NMI 7
`define SER_USED_MASK 16'h3FFF
`define NUM_EXT 8
`define NUM_SER 7
`define EVT_MASKABLE 0
`define EVT_NMI 1
`define EVT_LOCKED_WR 2
`endif

// file: shared/ilpc_pkg.sv
// Purpose: shared types of the level priority controller
// Assumes: nothing
// Notes: types only, constants live in the header
package ilpc_pkg;
   typedef logic [1:0] level_t;
   typedef logic [3:0] src_id_t;
   typedef logic [2:0] evt_t;
endpackage

// file: tb/ilpc_properties.sv
// Purpose: port-level checks of the level priority controller
// Assumes: one clock, async active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
module ilpc_properties #(
   parameter int NUM_EXT = 8,
   parameter int NUM_SER = 7
)(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NUM_EXT-1:0] ext_irq,
   input wire logic [NUM_SER-1:0] serial_irq,
   input wire logic nmi_req,
   input wire logic cpu_accept,
   input wire logic req_valid,
   input wire logic req_nmi,
   input wire ilpc_pkg::src_id_t req_src
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request left without ack");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   rdata_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
      else $error("read data moved without request");
   accept_drop_a: assert property (cpu_accept && req_valid |=> !req_valid)
      else $error("request still shown after accept");
   nmi_valid_a: assert property (req_nmi |-> req_valid)
      else $error("nmi flag without request");
   idle_quiet_a: assert property ($past(ext_irq) == '0 && $past(serial_irq) == '0
      && !$past(nmi_req) |-> !req_valid)
      else $error("request shown with no source");
   src_range_a: assert property (req_valid && !req_nmi |-> req_src <= 4'hE)
      else $error("source index out of range");
endmodule // ilpc_properties

// file: tb/cpu_model.sv
// Purpose: cpu side that takes presented requests
// Assumes: request stays shown while its source is high
// Notes: hold lets the bench look at a request before it is taken
`timescale 1ns/1ps
module cpu_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic hold,
   output logic cpu_accept
);
   // random wait: sometimes prompt, sometimes slow
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         cpu_accept <= 1'h0;
      else
         cpu_accept <= req_valid && !hold && !cpu_accept && ($urandom % 3 == 0);
   end
endmodule // cpu_model

// file: tb/interrupt_level_priority_control_tb.sv
// Purpose: self-checking bench for the level priority controller
// Assumes: offsets are word indices, byte address is four times index
// Notes: random levels and sources from a fixed seed
`timescale 1ns/1ps
`include "ilpc_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module interrupt_level_priority_control_tb;
   logic sys_clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, nmi_req = 0, hold = 1;
   logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, q;
   logic [3:0] wb_sel_i = 0;
   logic [7:0] ext_irq = 0;
   logic [6:0] serial_irq = 0;
   logic [15:0] el, sl;
   logic wb_ack_o, cpu_accept, req_valid, req_nmi, irq_out;
   ilpc_pkg::src_id_t req_src;
   ilpc_pkg::level_t req_level;
   int num_errors = 0, comparisons = 0;
   interrupt_level_priority_control i_interrupt_level_priority_control (.sys_clk(sys_clk),
      .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ext_irq(ext_irq), .serial_irq(serial_irq), .nmi_req(nmi_req),
      .cpu_accept(cpu_accept), .req_valid(req_valid), .req_nmi(req_nmi), .req_src(req_src),
      .req_level(req_level), .irq_out(irq_out));
   cpu_model i_cpu_model (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .hold(hold),
      .cpu_accept(cpu_accept));
   initial forever #20 sys_clk = ~sys_clk;
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         num_errors++;
         tally_and_finish;
      end
   endtask
   task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] d,
      input logic [3:0] s);
      int n;
      @(posedge sys_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= {14'h0, idx, 2'h0};
      wb_sel_i <= s;
      wb_dat_i <= {16'h0, d};
      for (n = 0; n < 20 && wb_ack_o !== 1'h1; n++) @(posedge sys_clk);
      bound(n, 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask
   task automatic rd(input logic [15:0] idx, input logic [15:0] e);
      wb(1'h0, idx, 16'h0, 4'h3);
      `CHK(q, {16'h0, e})
   endtask
   // waits for one accept, then holds the cpu off again
   task automatic take;
      int n;
      hold <= 1'h0;
      for (n = 0; n < 50 && cpu_accept !== 1'h1; n++) @(posedge sys_clk);
      hold <= 1'h1;
      bound(n, 50);
   endtask
   function automatic logic [5:0] win(input logic [7:0] e, input logic [6:0] s);
      logic [14:0] a;
      logic [29:0] l;
      logic [5:0] r;
      a = {s, e};
      l = {sl[13:0], el};
      r = 6'h3F;
      for (int i = 0; i < 15; i++)
         if (a[i] && (r == 6'h3F || l[2*i+:2] > r[5:4]))
            r = {l[2*i+:2], 4'(i)};
      return r;
   endfunction
   initial
   begin
      void'($urandom(32'h75AEEC45));
      repeat (10) @(posedge sys_clk);
      rstn <= 1'h1;
      rd(`OFS_EXT_LEVEL, `RST_LEVEL);
      rd(`OFS_SER_LEVEL, `RST_LEVEL);
      rd(`OFS_IN_SERVICE, 16'h0000);
      rd(`OFS_ENABLE, 16'h0000);
      wb(1'h1, `OFS_EXT_LEVEL, 16'hFFFF, 4'h3);
      rd(`OFS_EXT_LEVEL, 16'h0000);
      rd(`OFS_EVT_STATUS, 16'h0004);
      wb(1'h1, `OFS_ENABLE, 16'h0001, 4'h3);
      rd(16'hF0F0, 16'h0000);
      repeat (20)
      begin
         el = 16'($urandom);
         sl = 16'($urandom) & `SER_USED_MASK;
         ext_irq <= 8'h00;
         serial_irq <= 7'h00;
         wb(1'h1, `OFS_EXT_LEVEL, el, 4'h3);
         wb(1'h1, `OFS_SER_LEVEL, sl | 16'hC000, 4'h3);
         rd(`OFS_EXT_LEVEL, el);
         rd(`OFS_SER_LEVEL, sl);
         ext_irq <= 8'($urandom);
         serial_irq <= 7'($urandom);
         repeat (3) @(posedge sys_clk);
         `CHK(req_valid, |{ext_irq, serial_irq})
         if (req_valid === 1'h1)
            `CHK({req_level, req_src}, win(ext_irq, serial_irq))
      end
      ext_irq <= 8'h00;
      serial_irq <= 7'h00;
      wb(1'h1, `OFS_EXT_LEVEL, 16'h5AC3, 4'h1);
      rd(`OFS_EXT_LEVEL, {el[15:8], 8'hC3});
      wb(1'h1, `OFS_EXT_LEVEL, 16'h0003, 4'h3);
      ext_irq <= 8'h03;
      repeat (3) @(posedge sys_clk);
      `CHK({req_level, req_src}, 6'h30)
      take;
      ext_irq <= 8'h02;
      repeat (3) @(posedge sys_clk);
      `CHK(req_valid, 1'h0)
      rd(`OFS_IN_SERVICE, 16'h0008);
      nmi_req <= 1'h1;
      repeat (3) @(posedge sys_clk);
      `CHK(req_nmi, 1'h1)
      take;
      nmi_req <= 1'h0;
      ext_irq <= 8'h03;
      repeat (3) @(posedge sys_clk);
      `CHK(req_valid, 1'h0)
      ext_irq <= 8'h02;
      rd(`OFS_IN_SERVICE, 16'h0088);
      wb(1'h1, `OFS_IN_SERVICE, 16'h0000, 4'h3);
      rd(`OFS_IN_SERVICE, 16'h0008);
      wb(1'h1, `OFS_IN_SERVICE, 16'h0000, 4'h3);
      repeat (2) @(posedge sys_clk);
      `CHK({req_valid, req_src}, 5'h11)
      rd(`OFS_EVT_STATUS, 16'h0007);
      `CHK(irq_out, 1'h0)
      wb(1'h1, `OFS_EVT_MASK, 16'h0002, 4'h3);
      repeat (3) @(posedge sys_clk);
      `CHK(irq_out, 1'h1)
      wb(1'h1, `OFS_EVT_STATUS, 16'h0002, 4'h3);
      repeat (3) @(posedge sys_clk);
      `CHK(irq_out, 1'h0)
      rd(`OFS_EVT_STATUS, 16'h0005);
      tally_and_finish;
   end
endmodule // interrupt_level_priority_control_tb
bind interrupt_level_priority_control ilpc_properties #(.NUM_EXT(NUM_EXT), .NUM_SER(NUM_SER))
   i_ilpc_properties (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq(ext_irq),
   .serial_irq(serial_irq), .nmi_req(nmi_req), .cpu_accept(cpu_accept),
   .req_valid(req_valid), .req_nmi(req_nmi), .req_src(req_src));
